// [design/tcec_core.sv]
// Summary of operation
// - Switch flips after 64 consecutive charge-up pulses
// - Oscillator frequency code resets to 100
// - Address pin low primary, high secondary
// - Clock out, when enabled, carries the selected clock at either address
// - External clock selected shuts internal oscillator
// - Interrupt output ORs cascade input with own
module tcec_core #(
    parameter int NUM_CH = tcec_pkg::NUM_CH,
    parameter int DEBOUNCE_PULSES = tcec_pkg::DEBOUNCE_PULSES,
    parameter int INT_PULSE_CYCLES = tcec_pkg::INT_PULSE_CYCLES
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link clock: charge-up pulse domain
    input wire logic charge_up_pulse,
    input wire logic [NUM_CH-1:0] sense_raw,
    // Configuration
    input wire logic [2:0] osc_freq_write,
    input wire logic osc_freq_write_en,
    input wire logic use_ext_clk,
    input wire logic clk_out_en,
    input wire logic addr_select_pin,
    input wire logic int_over_i2c,
    input wire logic osc_clk,
    input wire logic ext_clk_in,
    // Cascade
    input wire logic cascade_int_in,
    input wire logic int_ack,
    // Status and outputs
    output logic [NUM_CH-1:0] channel_state,
    output logic [2:0] osc_freq_select,
    output logic [6:0] slave_addr,
    output logic osc_enable,
    output logic clk_out,
    output logic int_out,
    output logic i2c_int_pulse
);
    localparam int PW = $clog2(INT_PULSE_CYCLES + 1);

    if (NUM_CH < 2 || NUM_CH > 8) begin : g_bad_num_ch
        $error("NUM_CH must be 2 to 8");
    end
    if (INT_PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("INT_PULSE_CYCLES must be at least 1");
    end

    // Link domain: sample raw inputs and debounce on every rising charge-up pulse edge
    logic rst_link_meta_ff;
    logic rst_link_n_ff;
    logic [NUM_CH-1:0] raw_link;
    logic [NUM_CH-1:0] deb_link;
    logic [NUM_CH-1:0] held_link_ff;
    logic req_link_ff;
    logic ack_link;
    // System-domain acknowledge, declared here because the link side reads it
    logic ack_sys_ff;

    always_ff @(posedge charge_up_pulse) begin
        rst_link_meta_ff <= rst_n;
        rst_link_n_ff <= rst_link_meta_ff;
    end

    tcec_sync #(.WIDTH(NUM_CH)) u_raw_sync (
        .clk(charge_up_pulse),
        .rst_n(rst_link_n_ff),
        .async_in(sense_raw),
        .sync_out(raw_link)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tcec_debounce #(.PULSES(DEBOUNCE_PULSES)) u_deb (
                .clk(charge_up_pulse),
                .rst_n(rst_link_n_ff),
                .sample_en(1'b1),
                .raw_in(raw_link[g]),
                .state_out(deb_link[g])
            );
        end
    endgenerate

    // Toggle handshake: a pair of channels flips on one edge, so the word
    // must cross whole; a new word waits until the last one was taken
    always_ff @(posedge charge_up_pulse) begin
        if (!rst_link_n_ff) begin
            held_link_ff <= '0;
            req_link_ff <= 1'b0;
        end else if ((deb_link != held_link_ff) && (req_link_ff == ack_link)) begin
            held_link_ff <= deb_link;
            req_link_ff <= !req_link_ff;
        end
    end

    tcec_sync #(.WIDTH(1)) u_ack_sync (
        .clk(charge_up_pulse),
        .rst_n(rst_link_n_ff),
        .async_in(ack_sys_ff),
        .sync_out(ack_link)
    );

    // System domain
    logic req_sys;
    logic [1:0] strap_wait_ff;
    logic [NUM_CH-1:0] channel_state_ff;
    logic [2:0] osc_freq_ff;
    logic [6:0] addr_ff;
    logic addr_sampled_ff;
    logic osc_en_ff;
    logic clk_out_ff;
    logic own_int_ff;
    logic int_out_ff;
    logic i2c_pulse_ff;
    logic [PW-1:0] pulse_cnt_ff;
    logic [3:0] pins_sync;
    logic addr_pin_s;
    logic casc_int_s;
    logic osc_clk_s;
    logic ext_clk_s;
    logic change;

    // Only the toggle passes flops; the held word is stable when it is read
    tcec_sync #(.WIDTH(1)) u_req_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .async_in(req_link_ff),
        .sync_out(req_sys)
    );

    tcec_sync #(.WIDTH(4)) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .async_in({addr_select_pin, cascade_int_in, osc_clk, ext_clk_in}),
        .sync_out(pins_sync)
    );

    assign addr_pin_s = pins_sync[3];
    assign casc_int_s = pins_sync[2];
    assign osc_clk_s = pins_sync[1];
    assign ext_clk_s = pins_sync[0];

    // One cycle per new word: the acknowledge matches the request next cycle
    assign change = req_sys ^ ack_sys_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_sys_ff <= 1'b0;
            channel_state_ff <= '0;
        end else if (change) begin
            ack_sys_ff <= req_sys;
            channel_state_ff <= held_link_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_freq_ff <= tcec_pkg::OSC_FREQ_RESET;
        end else if (osc_freq_write_en) begin
            osc_freq_ff <= osc_freq_write;
        end
    end

    // Strap taken once, after the pin synchroniser has refilled past reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_wait_ff <= '0;
            addr_sampled_ff <= 1'b0;
            addr_ff <= tcec_pkg::ADDR_PRIMARY;
        end else if (strap_wait_ff != 2'(tcec_pkg::SYNC_STAGES)) begin
            strap_wait_ff <= strap_wait_ff + 2'h1;
        end else if (!addr_sampled_ff) begin
            addr_sampled_ff <= 1'b1;
            addr_ff <= addr_pin_s ? tcec_pkg::ADDR_SECONDARY : tcec_pkg::ADDR_PRIMARY;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_en_ff <= 1'b1;
            clk_out_ff <= 1'b0;
        end else begin
            osc_en_ff <= !use_ext_clk;
            clk_out_ff <= clk_out_en & (use_ext_clk ? ext_clk_s : osc_clk_s);
        end
    end

    // Own interrupt: change sets, host ack clears; set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            own_int_ff <= 1'b0;
        end else if (change) begin
            own_int_ff <= 1'b1;
        end else if (int_ack) begin
            own_int_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_out_ff <= 1'b0;
        end else begin
            int_out_ff <= own_int_ff | casc_int_s | change;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pulse_cnt_ff <= '0;
            i2c_pulse_ff <= 1'b0;
        end else if (change && int_over_i2c) begin
            pulse_cnt_ff <= PW'(INT_PULSE_CYCLES - 1);
            i2c_pulse_ff <= 1'b1;
        end else if (pulse_cnt_ff != '0) begin
            pulse_cnt_ff <= pulse_cnt_ff - PW'(1);
        end else begin
            i2c_pulse_ff <= 1'b0;
        end
    end

    assign channel_state = channel_state_ff;
    assign osc_freq_select = osc_freq_ff;
    assign slave_addr = addr_ff;
    assign osc_enable = osc_en_ff;
    assign clk_out = clk_out_ff;
    assign int_out = int_out_ff;
    assign i2c_int_pulse = i2c_pulse_ff;
endmodule : tcec_core

// [design/tcec_pkg.sv]
package tcec_pkg;
    localparam int NUM_CH = 8;
    // Consecutive charge-up pulses needed to flip a debounced channel
    localparam int DEBOUNCE_PULSES = 64;
    localparam int SAMPLE_RATE_HZ = 1000;
    localparam logic [2:0] OSC_FREQ_RESET = 3'h4;
    localparam int OSC_NOMINAL_KHZ = 80;
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int INT_PULSE_NS = 2000;
    localparam int INT_PULSE_CYCLES = (INT_PULSE_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    localparam logic [6:0] ADDR_PRIMARY = 7'h20;
    localparam logic [6:0] ADDR_SECONDARY = 7'h21;
    localparam int SYNC_STAGES = 2;
endpackage : tcec_pkg

// [design/tcec_sync.sv]
module tcec_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : tcec_sync

// [design/tcec_debounce.sv]
module tcec_debounce #(
    parameter int PULSES = tcec_pkg::DEBOUNCE_PULSES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_en,
    input wire logic raw_in,
    output logic state_out
);
    localparam int CW = $clog2(PULSES + 1);

    logic [CW-1:0] cnt_ff;
    logic state_ff;

    if (PULSES < 1) begin : g_bad_pulses
        $error("PULSES must be at least 1");
    end

    // Any pulse that agrees with the current state restarts the count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            state_ff <= 1'b0;
        end else if (sample_en) begin
            if (raw_in == state_ff) begin
                cnt_ff <= '0;
            end else if (cnt_ff == CW'(PULSES - 1)) begin
                cnt_ff <= '0;
                state_ff <= raw_in;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    assign state_out = state_ff;
endmodule : tcec_debounce

// [verification/tcec_core_monitor.sv]
module tcec_core_monitor #(
    parameter int INT_PULSE_CYCLES = 100
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [2:0] osc_freq_write,
    input wire logic osc_freq_write_en,
    input wire logic use_ext_clk,
    input wire logic clk_out_en,
    input wire logic addr_select_pin,
    input wire logic int_over_i2c,
    input wire logic cascade_int_in,
    // Outputs
    input wire logic [7:0] channel_state,
    input wire logic [2:0] osc_freq_select,
    input wire logic [6:0] slave_addr,
    input wire logic osc_enable,
    input wire logic clk_out,
    input wire logic int_out,
    input wire logic i2c_int_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] pcnt_ff;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !i2c_int_pulse) begin
            pcnt_ff <= 8'h00;
        end else begin
            pcnt_ff <= pcnt_ff + 8'h01;
        end
    end
    sequence s_change;
        channel_state != $past(channel_state);
    endsequence
    sequence s_pulse_req;
        s_change ##0 int_over_i2c;
    endsequence
    chk_osc_reset: assert property ($rose(rst_n) |-> osc_freq_select == 3'h4)
        else $error("osc code not 4 after reset");
    chk_osc_load: assert property (osc_freq_write_en |=> osc_freq_select == $past(osc_freq_write))
        else $error("osc code not loaded");
    chk_addr_strap: assert property ($rose(rst_n) ##6 1 |-> slave_addr == (addr_select_pin ? 7'h21 : 7'h20))
        else $error("address does not follow strap");
    chk_osc_shutdown: assert property (1 |=> osc_enable == !$past(use_ext_clk))
        else $error("oscillator enable wrong");
    chk_clk_gate: assert property (!clk_out_en |=> !clk_out)
        else $error("clock out while disabled");
    chk_cascade_or: assert property (cascade_int_in |-> ##[1:4] int_out)
        else $error("cascade interrupt lost");
    chk_event_int: assert property (s_change |-> ##[0:1] int_out)
        else $error("no interrupt on change");
    chk_pulse_start: assert property (s_pulse_req |-> ##[1:2] i2c_int_pulse)
        else $error("no bus interrupt pulse");
    chk_pulse_width: assert property ($fell(i2c_int_pulse) |-> pcnt_ff == 8'(INT_PULSE_CYCLES))
        else $error("bus interrupt pulse width wrong");
endmodule : tcec_core_monitor
bind tcec_core tcec_core_monitor #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) tcec_core_monitor_i (.sys_clk, .rst_n,
    .osc_freq_write, .osc_freq_write_en, .use_ext_clk, .clk_out_en, .addr_select_pin, .int_over_i2c,
    .cascade_int_in, .channel_state, .osc_freq_select, .slave_addr, .osc_enable, .clk_out, .int_out, .i2c_int_pulse);

// [verification/tcec_host_model.sv]
module tcec_host_model (
    // System
    input wire logic sys_clk,
    input wire logic rst_n,
    // Device side
    input wire logic int_out,
    input wire logic [7:0] channel_state,
    output logic int_ack,
    output logic [4:0] sensor_id
);
    timeunit 1ns;
    timeprecision 1ps;
    function automatic logic [4:0] pair_id(input logic [7:0] s);
        logic [4:0] n;
        logic [4:0] id;
        n = 5'h00;
        id = 5'h00;
        for (int i = 0; i < 8; i++) begin
            for (int j = i + 1; j < 8; j++) begin
                n = n + 5'h01;
                if (s == 8'((1 << i) | (1 << j))) begin
                    id = n;
                end
            end
        end
        return id;
    endfunction : pair_id
    // Acks every other cycle so a standing cascade request cannot hide a stuck ack
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_ack <= 1'b0;
            sensor_id <= 5'h00;
        end else begin
            int_ack <= int_out && !int_ack;
            if (int_out) begin
                sensor_id <= pair_id(channel_state);
            end
        end
    end
endmodule : tcec_host_model

// [verification/tcec_core_tb.sv]
module tcec_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, charge_up_pulse = 1'b0, osc_clk = 1'b0, ext_clk_in = 1'b0;
    logic [7:0] sense_raw = 8'h00;
    logic [2:0] osc_freq_write = 3'h0;
    logic osc_freq_write_en = 1'b0, use_ext_clk = 1'b0, clk_out_en = 1'b0, addr_select_pin = 1'b0;
    logic int_over_i2c = 1'b1, cascade_int_in = 1'b0;
    logic int_ack, osc_enable, clk_out, int_out, i2c_int_pulse;
    logic [7:0] channel_state;
    logic [2:0] osc_freq_select;
    logic [6:0] slave_addr;
    logic [4:0] sensor_id;
    logic [7:0] pat [3] = '{8'h03, 8'h24, 8'hC0};
    int ia [3] = '{0, 2, 6};
    int ja [3] = '{1, 5, 7};
    int n_fail = 0, tests_run = 0, cyc = 0, hi = 0;
    always #10 sys_clk = ~sys_clk;
    initial #7 forever #15 charge_up_pulse = ~charge_up_pulse;
    always #200 osc_clk = ~osc_clk;
    always #310 ext_clk_in = ~ext_clk_in;
    tcec_core #(.DEBOUNCE_PULSES(4)) tcec_core_i (.sys_clk, .rst_n, .charge_up_pulse, .sense_raw, .osc_freq_write,
        .osc_freq_write_en, .use_ext_clk, .clk_out_en, .addr_select_pin, .int_over_i2c, .osc_clk, .ext_clk_in,
        .cascade_int_in, .int_ack, .channel_state, .osc_freq_select, .slave_addr, .osc_enable, .clk_out,
        .int_out, .i2c_int_pulse);
    tcec_host_model tcec_host_model_i (.sys_clk, .rst_n, .int_out, .channel_state, .int_ack, .sensor_id);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // Reset spans 8 link edges too, since the link side resyncs it
    task automatic do_reset(input logic pin);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        addr_select_pin <= pin;
        repeat (13) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask : do_reset
    // Long tail lets the bus pulse end before the next change
    task automatic sense(input logic [7:0] v, input int hold);
        @(posedge sys_clk);
        sense_raw <= v;
        repeat (hold) @(posedge charge_up_pulse);
        repeat (120) @(posedge sys_clk);
    endtask : sense
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        do_reset(1'b0);
        chk("osc_freq_select", 8'h04, 8'(osc_freq_select));
        chk("slave_addr", 8'h20, 8'(slave_addr));
        chk("osc_enable", 8'h01, 8'(osc_enable));
        osc_freq_write <= 3'h2;
        osc_freq_write_en <= 1'b1;
        @(posedge sys_clk);
        osc_freq_write_en <= 1'b0;
        use_ext_clk <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("osc_freq_select", 8'h02, 8'(osc_freq_select));
        chk("osc_enable", 8'h00, 8'(osc_enable));
        use_ext_clk <= 1'b0;
        // Only two samples of the glitch reach the counter, two short
        @(posedge sys_clk);
        sense_raw <= 8'h03;
        repeat (2) @(posedge charge_up_pulse);
        @(posedge sys_clk);
        sense_raw <= 8'h00;
        repeat (120) @(posedge sys_clk);
        chk("channel_state", 8'h00, channel_state);
        chk("int_out", 8'h00, 8'(int_out));
        for (int k = 0; k < 3; k++) begin
            sense(pat[k], 20);
            chk("channel_state", pat[k], channel_state);
            chk("sensor_id", 8'(ia[k] * (15 - ia[k]) / 2 + ja[k] - ia[k]), 8'(sensor_id));
            chk("int_out", 8'h00, 8'(int_out));
        end
        cascade_int_in <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk("int_out", 8'h01, 8'(int_out));
        cascade_int_in <= 1'b0;
        clk_out_en <= 1'b1;
        repeat (200) begin
            @(posedge sys_clk);
            hi += int'(clk_out);
        end
        chk("clk_out_active", 8'h01, 8'(hi > 0 && hi < 200));
        do_reset(1'b1);
        chk("slave_addr", 8'h21, 8'(slave_addr));
        chk("osc_freq_select", 8'h04, 8'(osc_freq_select));
        stop_test();
    end
endmodule : tcec_core_tb
